// File: hdl/tcef_regs.svh
// Purpose: constants of the event flag register block
// Assumes: 8-bit register port from the serial management slave
// Notes: definitions only
`ifndef TCEF_REGS_SVH
`define TCEF_REGS_SVH
`define TCEF_EVENT_FLAGS_ADDR 8'h13
`define TCEF_EVENT_FLAGS_RST 8'h00
`define TCEF_BIT_ACC_CH 3
`define TCEF_BIT_CUR_LVL 2
`define TCEF_BIT_DETACH 1
`define TCEF_BIT_ATTACH 0
`define TCEF_FLAG_MASK 8'h0f
`define TCEF_LVL_NONE 2'h0
`define TCEF_LVL_DEFAULT 2'h1
`define TCEF_LVL_1A5 2'h2
`define TCEF_LVL_3A0 2'h3
`endif

// File: hdl/tcef_pkg.sv
// Purpose: types of the event flag register block
// Assumes: nothing
// Notes: constants live in tcef_regs.svh
package tcef_pkg;
  typedef enum logic [1:0] {
    TCEF_LVL_NONE_E = 2'h0,
    TCEF_LVL_DEFAULT_E = 2'h1,
    TCEF_LVL_1A5_E = 2'h2,
    TCEF_LVL_3A0_E = 2'h3
  } tcef_level_t;
  typedef logic [3:0] tcef_flags_t;
endpackage

// File: hdl/tcef_event_detect.sv
// Purpose: turns detection levels into one-cycle event pulses
// Assumes: level inputs come from logic on i_mclk
// Notes: a pulse lasts one cycle
`timescale 1ns/1ns
`include "tcef_regs.svh"
module tcef_event_detect (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_attached,
  input wire logic i_accessory_present,
  input wire logic i_audio_accessory_found,
  input wire logic i_debug_accessory_found,
  input wire tcef_pkg::tcef_level_t i_advertised_current_level,
  output logic [3:0] o_events
);
  logic att_ff;
  logic nxt_att;
  logic acc_ff;
  logic nxt_acc;
  logic [1:0] lvl_ff;
  logic [1:0] nxt_lvl;
  logic resolved;
  logic [3:0] ev;

  always_comb begin
    resolved = i_audio_accessory_found | i_debug_accessory_found;
    nxt_att = i_attached;
    nxt_acc = i_accessory_present;
    nxt_lvl = i_advertised_current_level;
    ev = 4'h0;
    ev[`TCEF_BIT_ACC_CH] = acc_ff & resolved & ~i_accessory_present;
    ev[`TCEF_BIT_CUR_LVL] = (lvl_ff != i_advertised_current_level);
    ev[`TCEF_BIT_DETACH] = att_ff & ~i_attached;
    ev[`TCEF_BIT_ATTACH] = ~att_ff & i_attached;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      att_ff <= 1'b0;
      acc_ff <= 1'b0;
      lvl_ff <= `TCEF_LVL_NONE;
    end else begin
      att_ff <= nxt_att;
      acc_ff <= nxt_acc;
      lvl_ff <= nxt_lvl;
    end
  end

  assign o_events = ev;
endmodule

// File: hdl/tcef_event_flags.sv
// Purpose: sticky event flags with write-one-to-clear and masked interrupt request
// Assumes: register port is a synchronous single-cycle strobe from the serial slave
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ns
`include "tcef_regs.svh"
// Operation
// - Accessory-change flag bit 3 sets when accessory presence drops while an audio or debug accessory is found.
// - Current-level-change flag bit 2 sets whenever the advertised current level changes.
// - Detach flag bit 1 sets when an attached device or accessory is removed.
// - Attach flag bit 0 sets when a device or accessory of reported type attaches.
// - The global mask blocks the interrupt request while flags still latch.
// - Each per-event mask bit blocks only its own flag from the interrupt request.
// - The current level code is 00 none, 01 default, 10 1.5 A, 11 3 A.
module tcef_event_flags (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_attached,
  input wire logic i_accessory_present,
  input wire logic i_audio_accessory_found,
  input wire logic i_debug_accessory_found,
  input wire tcef_pkg::tcef_level_t i_advertised_current_level,
  input wire logic i_global_mask,
  input wire logic [3:0] i_event_mask,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_int_req
);
  // ************************************************************
  // event detection
  // ************************************************************
  logic [3:0] events;

  tcef_event_detect u_detect (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_attached(i_attached),
    .i_accessory_present(i_accessory_present),
    .i_audio_accessory_found(i_audio_accessory_found),
    .i_debug_accessory_found(i_debug_accessory_found),
    .i_advertised_current_level(i_advertised_current_level),
    .o_events(events)
  );

  // ************************************************************
  // decode helpers
  // ************************************************************
  // the flag register is the only address behind this port
  function automatic logic flags_hit(input logic [7:0] addr);
    flags_hit = (addr == `TCEF_EVENT_FLAGS_ADDR);
  endfunction

  // flags that a write clears; bits 7:4 have no storage, so their ones are dropped here
  function automatic tcef_pkg::tcef_flags_t clear_mask(
    input logic wr,
    input logic [7:0] addr,
    input logic [7:0] wdata
  );
    clear_mask = 4'h0;
    if (wr && flags_hit(addr)) begin
      clear_mask = 4'(wdata & `TCEF_FLAG_MASK);
    end
  endfunction

  function automatic logic [7:0] read_word(input tcef_pkg::tcef_flags_t flags);
    read_word = {4'h0, flags} & `TCEF_FLAG_MASK;
  endfunction

  function automatic tcef_pkg::tcef_flags_t pending(
    input tcef_pkg::tcef_flags_t flags,
    input logic [3:0] mask
  );
    pending = flags & ~mask;
  endfunction

  // ************************************************************
  // flag register
  // ************************************************************
  tcef_pkg::tcef_flags_t flags_ff;
  tcef_pkg::tcef_flags_t nxt_flags;
  tcef_pkg::tcef_flags_t clr;

  always_comb begin
    clr = clear_mask(i_reg_wr, i_reg_addr, i_reg_wdata);
    // set applied after the clear: an event in the clearing cycle is never lost
    nxt_flags = (flags_ff & ~clr) | events;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags_ff <= 4'(`TCEF_EVENT_FLAGS_RST);
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = rdata_ff;
    if (i_reg_rd) begin
      // other addresses read zero rather than echo the flags
      nxt_rdata = flags_hit(i_reg_addr) ? read_word(flags_ff) : 8'h00;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ************************************************************
  // interrupt request
  // ************************************************************
  logic int_ff;
  logic nxt_int;

  always_comb begin
    // masks only gate the request, the flags keep latching underneath
    nxt_int = 1'b0;
    if (!i_global_mask) begin
      nxt_int = |pending(nxt_flags, i_event_mask);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      int_ff <= 1'b0;
    end else begin
      int_ff <= nxt_int;
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_int_req = int_ff;

  // ************************************************************
  // checks
  // ************************************************************
  a_attach_sets: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $rose(i_attached) |=> ##1 flags_ff[`TCEF_BIT_ATTACH])
    else $error("attach flag not set after attach");
  a_detach_sets: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $fell(i_attached) |=> ##1 flags_ff[`TCEF_BIT_DETACH])
    else $error("detach flag not set after detach");
  a_level_sets: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_advertised_current_level != $past(i_advertised_current_level)) |=> ##1 flags_ff[`TCEF_BIT_CUR_LVL])
    else $error("level flag not set after level change");
  a_acc_sets: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    ($past(i_accessory_present) && !i_accessory_present
     && (i_audio_accessory_found || i_debug_accessory_found)) |=> ##1 flags_ff[`TCEF_BIT_ACC_CH])
    else $error("accessory flag not set after resolve");

  // ************************************************************
  // checks: clearing and reading
  // ************************************************************
  a_flag_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (flags_ff[`TCEF_BIT_ATTACH] && !(i_reg_wr && i_reg_addr == `TCEF_EVENT_FLAGS_ADDR
     && i_reg_wdata[`TCEF_BIT_ATTACH])) |=> flags_ff[`TCEF_BIT_ATTACH])
    else $error("flag dropped without clear");

  a_detach_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (flags_ff[`TCEF_BIT_DETACH] && !(i_reg_wr && i_reg_addr == `TCEF_EVENT_FLAGS_ADDR
     && i_reg_wdata[`TCEF_BIT_DETACH])) |=> flags_ff[`TCEF_BIT_DETACH])
    else $error("detach flag dropped without clear");

  a_level_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (flags_ff[`TCEF_BIT_CUR_LVL] && !(i_reg_wr && i_reg_addr == `TCEF_EVENT_FLAGS_ADDR
     && i_reg_wdata[`TCEF_BIT_CUR_LVL])) |=> flags_ff[`TCEF_BIT_CUR_LVL])
    else $error("level flag dropped without clear");

  a_acc_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (flags_ff[`TCEF_BIT_ACC_CH] && !(i_reg_wr && i_reg_addr == `TCEF_EVENT_FLAGS_ADDR
     && i_reg_wdata[`TCEF_BIT_ACC_CH])) |=> flags_ff[`TCEF_BIT_ACC_CH])
    else $error("accessory flag dropped without clear");

  a_clear_works: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (flags_ff[`TCEF_BIT_ATTACH] && !events[`TCEF_BIT_ATTACH] && i_reg_wr
     && i_reg_addr == `TCEF_EVENT_FLAGS_ADDR && i_reg_wdata[`TCEF_BIT_ATTACH]) |=> !flags_ff[`TCEF_BIT_ATTACH])
    else $error("attach flag survived its clear");

  a_set_wins: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (events != 4'h0) |=> ((flags_ff & $past(events)) == $past(events)))
    else $error("event lost against a clear");

  a_no_spurious: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (events == 4'h0) |=> ((flags_ff & ~$past(flags_ff)) == 4'h0))
    else $error("flag set with no event");

  a_upper_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_reg_rdata[7:4] == 4'h0)
    else $error("reserved bits read nonzero");

  a_read_value: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_reg_rd && i_reg_addr == `TCEF_EVENT_FLAGS_ADDR) |=> (o_reg_rdata == {4'h0, $past(flags_ff)}))
    else $error("read data differs from the flags");

  a_read_other: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_reg_rd && i_reg_addr != `TCEF_EVENT_FLAGS_ADDR) |=> (o_reg_rdata == 8'h00))
    else $error("other address read nonzero");

  a_rdata_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");

  // ************************************************************
  // checks: interrupt request
  // ************************************************************
  a_global_mask: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_global_mask |=> !o_int_req)
    else $error("request despite global mask");

  a_event_mask: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!i_global_mask && !i_reg_wr && ((flags_ff & ~i_event_mask) != 4'h0)) |=> o_int_req)
    else $error("unmasked flag gave no request");

  a_masked_quiet: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (((flags_ff | events) & ~i_event_mask) == 4'h0) |=> !o_int_req)
    else $error("request from masked flags");
endmodule

// File: verif/tcef_host_model.sv
// Purpose: host side of the flag register port
// Assumes: one-cycle strobes, driven on the falling edge
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ns
module tcef_host_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_reg_rdata,
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_wdata
);
  // ****
  // bus cycles
  // ****
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(negedge i_mclk);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_mclk);
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    // read data is registered, so it lands one edge after the strobe
    @(negedge i_mclk);
    d = i_reg_rdata;
  endtask
endmodule

// File: verif/typec_event_flag_register_tb.sv
// Purpose: self-checking bench of the event flag register
// Assumes: flags settle within four cycles of an input change
// Notes: inputs move on the falling edge
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module typec_event_flag_register_tb;
  logic i_mclk, i_rst_b, att, pres, aud, dbg, gm, wr, rd, irq;
  logic [3:0] em;
  logic [7:0] addr, wdata, rdata, rv;
  tcef_pkg::tcef_level_t lvl;
  int failures = 0;
  int samples_checked = 0;
  tcef_event_flags i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_attached(att), .i_accessory_present(pres),
    .i_audio_accessory_found(aud), .i_debug_accessory_found(dbg), .i_advertised_current_level(lvl),
    .i_global_mask(gm), .i_event_mask(em), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_int_req(irq));
  tcef_host_model i_host (.i_mclk(i_mclk), .i_reg_rdata(rdata), .o_reg_addr(addr), .o_reg_wr(wr),
    .o_reg_rd(rd), .o_reg_wdata(wdata));
  // ****
  // helpers
  // ****
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic expect_flags(input logic [7:0] e);
    repeat (4) @(negedge i_mclk);
    i_host.rd(8'h13, rv);
    `CHK(rv, e)
  endtask
  task automatic wait_irq(input logic e);
    repeat (2) @(negedge i_mclk);
    `CHK(irq, e)
  endtask
  // ****
  // sequence
  // ****
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    failures++;
    give_verdict();
  end
  initial begin
    {att, pres, aud, dbg, gm} = 5'h00;
    em = 4'h0;
    lvl = tcef_pkg::TCEF_LVL_NONE_E;
    i_rst_b = 1'b0;
    repeat (12) @(negedge i_mclk);
    i_rst_b = 1'b1;
    expect_flags(8'h00);
    att = 1'b1;
    expect_flags(8'h01);
    wait_irq(1'b1);
    em = 4'h1;
    wait_irq(1'b0);
    em = 4'he;
    wait_irq(1'b1);
    gm = 1'b1;
    wait_irq(1'b0);
    {gm, em} = 5'h00;
    i_host.rd(8'h12, rv);
    `CHK(rv, 8'h00)
    i_host.wr(8'h12, 8'h0f);
    expect_flags(8'h01);
    i_host.wr(8'h13, 8'hfe);
    expect_flags(8'h01);
    i_host.wr(8'h13, 8'h01);
    expect_flags(8'h00);
    wait_irq(1'b0);
    // flags keep latching under the global mask
    gm = 1'b1;
    att = 1'b0;
    expect_flags(8'h02);
    `CHK(irq, 1'b0)
    gm = 1'b0;
    wait_irq(1'b1);
    // clear and a new attach in the same cycle: the set must win
    fork
      i_host.wr(8'h13, 8'h03);
      begin
        @(negedge i_mclk);
        att = 1'b1;
      end
    join
    expect_flags(8'h01);
    i_host.wr(8'h13, 8'h01);
    // codes 1,2,3 then back to 0: every step is a change
    for (int i = 1; i < 5; i++) begin
      lvl = tcef_pkg::tcef_level_t'(i[1:0]);
      expect_flags(8'h04);
      i_host.wr(8'h13, 8'h04);
    end
    for (int j = 0; j < 2; j++) begin
      pres = 1'b1;
      aud = (j == 0);
      dbg = (j == 1);
      repeat (3) @(negedge i_mclk);
      pres = 1'b0;
      expect_flags(8'h08);
      i_host.wr(8'h13, 8'h08);
      {aud, dbg} = 2'h0;
    end
    // an accessory that leaves without resolving raises nothing
    pres = 1'b1;
    repeat (3) @(negedge i_mclk);
    pres = 1'b0;
    expect_flags(8'h00);
    give_verdict();
  end
endmodule
